// file: src/hoc_map.vh
// Register map, field positions and reset values for the host operation control word
`ifndef HOC_MAP_VH
`define HOC_MAP_VH

// ==========================================================
// Offsets
`define HOC_CTRL_OFFSET 12'h004
`define HOC_EVT_OFFSET 12'h00C
`define HOC_ADDR_W 12

// ==========================================================
// Field positions
`define HOC_FSTATE_LO 6
`define HOC_FSTATE_HI 7
`define HOC_BLE_BIT 5
`define HOC_CLE_BIT 4
`define HOC_ROUTE_BIT 8
`define HOC_CAPABLE_BIT 9
`define HOC_WAKE_EN_BIT 10

// ==========================================================
// Reset values
`define HOC_CTRL_RESET 32'h00000000
`define HOC_EVT_RESET 32'h00000000

`endif

// file: src/hoc_flag_bit.v
// One control flag that hardware reset clears and software reset keeps
`timescale 1ns/1ps
`default_nettype none

module hoc_flag_bit (
  // Clock and resets
  input wire core_clk,
  input wire reset,
  input wire soft_reset,
  // Write port
  input wire wr_en,
  input wire wr_val,
  // State
  output reg flag_q
);

  // ==========================================================
  // Storage
  // Soft reset is deliberately absent here: the flag survives it
  always @(posedge core_clk) begin
    if (reset) begin
      flag_q <= 1'b0;
    end else if (wr_en) begin
      flag_q <= wr_val;
    end
  end

endmodule // hoc_flag_bit

`default_nettype wire

// file: src/hoc_control.v
// Host operation control register with APB access and interrupt routing
// Operation
// - Hardware alters only the state field
// - Capable bit: hard reset clears, soft keeps
// - Capable encoding: 0 unsupported, 1 supported
// - Routing bit: hard reset clears, soft keeps
// - Routing 0 bus interrupt, 1 management
`timescale 1ns/1ps
`default_nettype none
`include "hoc_map.vh"

module hoc_control (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // Controller software reset
  input wire soft_reset,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // Event inputs and controller state
  input wire [31:0] event_set,
  input wire state_load,
  input wire [1:0] state_val,
  // Outputs
  output wire [1:0] controller_functional_state,
  output wire bulk_list_enable,
  output wire control_list_enable,
  output wire remote_wake_capable,
  output wire interrupt_route_select,
  output reg bus_irq_q,
  output reg management_interrupt_path_q
);

  // ==========================================================
  // Decode
  wire acc = psel && penable;
  // Read data is fetched in the setup cycle, one edge ahead of the answer
  wire setup_rd = psel && !penable && !pwrite;
  // Full address compare; aliases of the two words are not decoded
  wire hit_ctrl = (paddr == `HOC_CTRL_OFFSET);
  wire hit_evt = (paddr == `HOC_EVT_OFFSET);
  wire hit_any = hit_ctrl || hit_evt;
  wire wr_ctrl = acc && pwrite && hit_ctrl;
  wire wr_evt = acc && pwrite && hit_evt;

  // ==========================================================
  // Handshake
  // Zero wait states: every access ends in its first access cycle
  assign pready = 1'b1;
  // Unmapped addresses answer with an error
  assign pslverr = acc && !hit_any;

  // ==========================================================
  // Low control fields (cleared by either reset)
  // Soft reset clears these, unlike the two flags below
  reg [1:0] fstate_q;
  reg [1:0] fstate_d;
  reg ble_q;
  reg ble_d;
  reg cle_q;
  reg cle_d;

  always @* begin
    fstate_d = fstate_q;
    ble_d = ble_q;
    cle_d = cle_q;
    if (wr_ctrl) begin
      ble_d = pwdata[`HOC_BLE_BIT];
      cle_d = pwdata[`HOC_CLE_BIT];
      fstate_d = pwdata[`HOC_FSTATE_HI:`HOC_FSTATE_LO];
    end
    // Hardware state change wins over a software write in the same cycle
    if (state_load) begin
      fstate_d = state_val;
    end
  end

  always @(posedge core_clk) begin
    if (reset || soft_reset) begin
      fstate_q <= 2'h0;
      ble_q <= 1'b0;
      cle_q <= 1'b0;
    end else begin
      fstate_q <= fstate_d;
      ble_q <= ble_d;
      cle_q <= cle_d;
    end
  end

  // ==========================================================
  // Flags that survive soft reset
  hoc_flag_bit u_capable (
    .core_clk(core_clk),
    .reset(reset),
    .soft_reset(soft_reset),
    .wr_en(wr_ctrl),
    .wr_val(pwdata[`HOC_CAPABLE_BIT]),
    .flag_q(remote_wake_capable)
  );

  hoc_flag_bit u_route (
    .core_clk(core_clk),
    .reset(reset),
    .soft_reset(soft_reset),
    .wr_en(wr_ctrl),
    .wr_val(pwdata[`HOC_ROUTE_BIT]),
    .flag_q(interrupt_route_select)
  );

  // Wakeup enable has no function: not stored, reads zero
  wire remote_wake_enable = 1'b0;

  // ==========================================================
  // Event status, write one to clear, set wins
  reg [31:0] evt_q;
  reg [31:0] evt_d;
  // Writing a one clears that bit; zeros leave it alone
  wire [31:0] evt_clr = wr_evt ? pwdata : 32'h00000000;

  // A new event in the clearing cycle must not be lost
  always @* begin
    evt_d = (evt_q & ~evt_clr) | event_set;
  end

  always @(posedge core_clk) begin
    if (reset || soft_reset) begin
      evt_q <= `HOC_EVT_RESET;
    end else begin
      evt_q <= evt_d;
    end
  end

  // ==========================================================
  // Routing of latched events
  // Exactly one path carries pending events; the other stays low
  wire evt_pending = |evt_q;
  reg bus_irq_d;
  reg mgmt_irq_d;

  always @* begin
    bus_irq_d = 1'b0;
    mgmt_irq_d = 1'b0;
    if (evt_pending) begin
      if (interrupt_route_select) begin
        mgmt_irq_d = 1'b1;
      end else begin
        bus_irq_d = 1'b1;
      end
    end
  end

  // Soft reset empties the status, so both paths fall a cycle later
  always @(posedge core_clk) begin
    if (reset) begin
      bus_irq_q <= 1'b0;
      management_interrupt_path_q <= 1'b0;
    end else begin
      bus_irq_q <= bus_irq_d;
      management_interrupt_path_q <= mgmt_irq_d;
    end
  end

  // ==========================================================
  // Control word layout
  // Bit ten is never stored, so it always reads back zero
  wire [31:0] ctrl_word = {
    21'h000000,
    remote_wake_enable,
    remote_wake_capable,
    interrupt_route_select,
    fstate_q,
    ble_q,
    cle_q,
    4'h0
  };

  // ==========================================================
  // Read data
  reg [31:0] rdata_d;

  // Unmapped reads return zero alongside the error response
  always @* begin
    rdata_d = prdata;
    if (setup_rd) begin
      if (hit_ctrl) begin
        rdata_d = ctrl_word;
      end else if (hit_evt) begin
        rdata_d = evt_q;
      end else begin
        rdata_d = 32'h00000000;
      end
    end
  end

  // Only hardware reset clears the holding register
  always @(posedge core_clk) begin
    if (reset) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= rdata_d;
    end
  end

  // ==========================================================
  // Outputs
  assign controller_functional_state = fstate_q;
  assign bulk_list_enable = ble_q;
  assign control_list_enable = cle_q;

endmodule // hoc_control

`default_nettype wire

// file: tb/hoc_control_properties.sv
// Port checks for the host operation control word
`timescale 1ns/1ps
`default_nettype none
module hoc_control_chk (
  input wire logic core_clk, reset, soft_reset, psel, penable, pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic remote_wake_capable, interrupt_route_select,
  input wire logic bus_irq_q, management_interrupt_path_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire ctl = psel && penable && paddr == 12'h004;
  wire wr = ctl && pwrite;
  // ==========
  a_upper_zero: assert property (ctl && !pwrite |-> prdata[31:10] == 22'h0)
    else $error("upper bits not zero");
  a_cap_write: assert property (wr && !soft_reset |=>
    remote_wake_capable == $past(pwdata[9]))
    else $error("capable bit not stored");
  a_route_write: assert property (wr && !soft_reset |=>
    interrupt_route_select == $past(pwdata[8]))
    else $error("route bit not stored");
  // A reset edge legally clears both flags, so it is no hold cycle
  a_cap_hold: assert property (!wr && !reset |=> $stable(remote_wake_capable))
    else $error("capable bit changed");
  a_route_hold: assert property (!wr && !reset |=> $stable(interrupt_route_select))
    else $error("route bit changed");
  // Hardware reset itself is the cause, so no disable here
  a_hard_clear: assert property (disable iff (1'b0) reset |=>
    !remote_wake_capable && !interrupt_route_select)
    else $error("reset kept a flag");
  a_irq_excl: assert property (!(bus_irq_q && management_interrupt_path_q))
    else $error("both interrupt paths high");
  a_mgmt_route: assert property ($rose(management_interrupt_path_q) |->
    interrupt_route_select || $past(interrupt_route_select))
    else $error("management path without route");
  a_bus_route: assert property ($rose(bus_irq_q) |-> !$past(interrupt_route_select))
    else $error("bus path while routed to management");
  c_write: cover property (wr);
  c_mgmt: cover property (management_interrupt_path_q);
  c_bus: cover property (bus_irq_q);
endmodule // hoc_control_chk
bind hoc_control hoc_control_chk u_hoc_control_chk (.core_clk, .reset, .soft_reset, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .remote_wake_capable, .interrupt_route_select, .bus_irq_q,
  .management_interrupt_path_q);
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the host operation control word
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk = 0, reset = 1, soft_reset = 0, psel = 0, penable = 0, pwrite = 0;
  logic state_load = 0, pready, pslverr, bus_irq_q, mgmt, err;
  logic ble, cle, cap, route;
  logic [1:0] fstate;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, event_set = 0, prdata, rd;
  logic [1:0] state_val = 0;
  integer err_count = 0, samples_checked = 0;
  always #10 core_clk = ~core_clk;
  hoc_control u_hoc_control (.core_clk, .reset, .soft_reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .prdata, .event_set, .state_load, .state_val,
    .controller_functional_state(fstate), .bulk_list_enable(ble), .control_list_enable(cle),
    .remote_wake_capable(cap), .interrupt_route_select(route), .bus_irq_q,
    .management_interrupt_path_q(mgmt));
  // ==========
  task complete_run;
    if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Idle cycle after each transfer keeps drivers single per time step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer n;
    begin
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1;
      n = 0;
      @(posedge core_clk);
      while (pready !== 1'b1 && n < 20) begin
        n++;
        @(posedge core_clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge core_clk);
      if (n == 20) begin
        err_count++;
        complete_run;
      end
    end
  endtask
  task t_map;
    apb(0, 12'h004, 0);
    chk(rd, 0);
    apb(1, 12'h004, 32'hFFFFFBFF);
    chk({26'h0, cap, route, fstate, ble, cle}, 32'h0000003F);
    apb(0, 12'h004, 0);
    chk(rd, 32'h000003F0);
    apb(0, 12'h010, 0);
    chk({31'h0, err}, 1);
  endtask
  task t_soft;
    soft_reset <= 1;
    @(posedge core_clk);
    soft_reset <= 0;
    @(posedge core_clk);
    chk({26'h0, cap, route, fstate, ble, cle}, 32'h00000030);
    apb(0, 12'h004, 0);
    chk(rd, 32'h00000300);
  endtask
  task t_state;
    state_load <= 1;
    state_val <= 2'h2;
    @(posedge core_clk);
    state_load <= 0;
    apb(0, 12'h004, 0);
    chk(rd, 32'h00000380);
    chk({30'h0, fstate}, 32'h00000002);
  endtask
  task t_route;
    event_set <= 32'h1;
    @(posedge core_clk);
    event_set <= 0;
    repeat (2) @(posedge core_clk);
    chk({30'h0, bus_irq_q, mgmt}, 1);
    apb(0, 12'h00C, 0);
    chk(rd, 32'h00000001);
    apb(1, 12'h004, 32'h00000200);
    repeat (2) @(posedge core_clk);
    chk({30'h0, bus_irq_q, mgmt}, 2);
    apb(1, 12'h00C, 32'hFFFFFFFF);
    repeat (2) @(posedge core_clk);
    chk({30'h0, bus_irq_q, mgmt}, 0);
    apb(0, 12'h00C, 0);
    chk(rd, 0);
    reset <= 1;
    @(posedge core_clk);
    reset <= 0;
    @(posedge core_clk);
    chk({30'h0, cap, route}, 0);
    apb(0, 12'h004, 0);
    chk(rd, 0);
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 0;
    @(posedge core_clk);
    t_map;
    t_soft;
    t_state;
    t_route;
    complete_run;
  end
endmodule // tb_top
`default_nettype wire
